// ===== fe_rx_path.sv
// ============================================================================
// Receive coding path: MLT-3 to NRZ, descrambler, aligner, 5B/4B decoder,
// link monitor and false carrier count.
// Assumes rx_clk is the recovered bit clock and that the MAC samples on clk.
// ============================================================================
`timescale 1ns/10ps

// What this block does
// - Three-level symbols become binary NRZI first.
// - Recovered 125 MHz clock times receive stages.
// - NRZ feeds descrambler, aligner, or PCS.
// - Group received bits into 5-bit symbols.
// - Plain bit is scrambled XOR key.
// - Lock after twelve consecutive idle code-groups.
// - Hold timer 722 us, renewed by 58 idle bits.
// - Hold expiry drops lock and reacquires.
// - Aligner takes descrambler or NRZ bits.
// - J/K pair fixes the symbol boundary.
// - J/K after idle becomes 0101 0101.
// - Packet code-groups decode by table lookup.
// - Decoding stops on T/R or two idles.
// - End delimiter is 01101 then 00111.
// - Link-up after 395 us of signal detect.
// - Configuration bit forces signal detect active.
// - Option bit adds lock to link-up entry.
// - Idle to non-idle without J/K is bad.
// - Bad start gives RXER and 1110 nibbles.
// - Each bad start adds one to counter.
// - Equalization amount is readable by software.
module fe_rx_path
  import fe_rx_pkg::*;
#(
  parameter int HOLD_CYCLES   = HOLD_CYC,    // Descrambler hold period in bit clocks.
  parameter int LINKUP_CYCLES = LINKUP_CYC,  // Link qualify time in core clocks.
  parameter int FC_W          = 16           // False carrier counter width.
) (
  // Core clock and reset.
  input  wire logic            clk,
  input  wire logic            rst_n,
  // Recovered bit clock and line side.
  input  wire logic            rx_clk,
  input  wire logic [1:0]      mlt3_sym,
  input  wire logic [EQ_W-1:0] eq_amount,
  input  wire logic            sig_det,
  // Configuration from pcs_config_reg.
  input  wire pcs_cfg_s        cfg,
  // Nibble side towards the MAC.
  output logic [3:0]           rxd,
  output logic                 rx_dv,
  output logic                 rx_er,
  output logic                 rx_stb,
  output logic [4:0]           rx_sym,
  // Status.
  output logic                 link_up,
  output logic                 descr_locked,
  output logic [FC_W-1:0]      false_carrier_cnt,
  output logic [EQ_W-1:0]      eq_level
);

  localparam int HOLD_W = $clog2(HOLD_CYCLES + 1);    // Hold counter width.
  localparam int UP_W   = $clog2(LINKUP_CYCLES + 1);  // Link counter width.

  // Parameters the counters cannot serve are refused.
  if (HOLD_CYCLES < IDLE_PAIR || LINKUP_CYCLES < 2 || FC_W < 1) begin : g_bad_param
    $error("fe_rx_path: parameter out of range");
  end

  // ==========================================================================
  // Decoding table.
  // ==========================================================================
  // Maps a data code-group to {valid, nibble}; invalid groups give valid low.
  function automatic logic [4:0] dec5(input logic [4:0] s);
    case (s)
      5'h1e: dec5 = 5'h10;
      5'h09: dec5 = 5'h11;
      5'h14: dec5 = 5'h12;
      5'h15: dec5 = 5'h13;
      5'h0a: dec5 = 5'h14;
      5'h0b: dec5 = 5'h15;
      5'h0e: dec5 = 5'h16;
      5'h0f: dec5 = 5'h17;
      5'h12: dec5 = 5'h18;
      5'h13: dec5 = 5'h19;
      5'h16: dec5 = 5'h1a;
      5'h17: dec5 = 5'h1b;
      5'h1a: dec5 = 5'h1c;
      5'h1b: dec5 = 5'h1d;
      5'h1c: dec5 = 5'h1e;
      5'h1d: dec5 = 5'h1f;
      default: dec5 = 5'h00;
    endcase
  endfunction

  // ==========================================================================
  // Bit clock domain.
  // ==========================================================================
  // All state of the bit clock side except the reset synchronizer.
  typedef struct packed {
    logic [1:0]        cfg_s1;    // Bypass bits, first sync stage.
    logic [1:0]        cfg_s2;    // Bypass bits, second sync stage.
    logic              nrzi_q;    // Previous NRZI level.
    logic [LFSR_W-1:0] lfsr;      // Local key generator.
    logic [CNT_W-1:0]  match_cnt; // Consecutive correct key predictions.
    logic              locked;    // Descrambler in sync.
    logic [CNT_W-1:0]  idle_run;  // Consecutive plain ones while locked.
    logic [HOLD_W-1:0] hold_cnt;  // Hold timer.
    logic [9:0]        sh;        // Last ten plain bits.
    logic [3:0]        ones_run;  // Consecutive ones, saturating at two idles.
    rx_state_e         pst;       // Code-group state.
    logic [2:0]        bit_cnt;   // Bit index within the current group.
    logic              seen_one;  // J, or one idle or T, already seen.
    logic              tog;       // Flips when a new word is posted.
    rx_word_s          word;      // Word offered to the core clock.
  } link_st_s;

  link_st_s   ls;        // Registered bit clock state.
  link_st_s   nl;        // Next bit clock state.
  logic [1:0] lrst_q;    // Reset carried into the bit clock domain.
  logic       nrzi_now;  // Binary level of the current symbol.
  logic       nrz_bit;   // Decoded NRZ bit.
  logic       key;       // Key bit from the generator.
  logic       plain;     // Descrambled bit.
  logic       renew;     // Hold timer renewal.
  logic [4:0] sym;       // Group completed this bit.
  logic [4:0] dsym;      // Table result for sym.
  logic       emit;      // Post nl.word this bit.

  // Reset reaches the bit clock side through two flops.
  always_ff @(posedge rx_clk) begin
    lrst_q <= {lrst_q[0], rst_n};
  end

  // Next state of the descrambler, aligner and decoder.
  always_comb begin
    nl       = ls;
    emit     = 1'b0;
    nl.cfg_s1 = {cfg.descr_bypass, cfg.rx_bypass};
    nl.cfg_s2 = ls.cfg_s1;
    nrzi_now  = (mlt3_sym != MLT_ZERO);
    nrz_bit   = nrzi_now ^ ls.nrzi_q;
    nl.nrzi_q = nrzi_now;
    key       = ls.lfsr[TAP_A] ^ ls.lfsr[TAP_B];
    // Sync hunts on idle, where the key is the inverted line bit.
    if (!ls.locked) begin
      nl.lfsr     = {ls.lfsr[LFSR_W-2:0], ~nrz_bit};
      nl.hold_cnt = '0;
      nl.idle_run = '0;
      if (key == ~nrz_bit) begin
        if (ls.match_cnt == CNT_W'(LOCK_BITS - 1)) begin
          nl.locked    = 1'b1;
          nl.match_cnt = '0;
        end else begin
          nl.match_cnt = ls.match_cnt + 1'b1;
        end
      end else begin
        nl.match_cnt = '0;
      end
    end else begin
      nl.lfsr = {ls.lfsr[LFSR_W-2:0], key};
    end
    // Plain bit: descrambled, or the NRZ bit itself when bypassed.
    plain = ls.cfg_s2[1] ? nrz_bit : (nrz_bit ^ key);
    // Hold timer while locked.
    renew = 1'b0;
    if (ls.locked) begin
      nl.idle_run = plain ? ((ls.idle_run == CNT_W'(IDLE_RUN_BITS)) ? ls.idle_run
                                                                     : ls.idle_run + 1'b1)
                          : '0;
      // Once the run has reached 58 bits, every further idle bit renews the
      // timer, so a steady idle line never lets the hold period run out.
      renew = plain && (ls.idle_run >= CNT_W'(IDLE_RUN_BITS - 1));
      if (renew) begin
        nl.hold_cnt = '0;
      end else if (ls.hold_cnt == HOLD_W'(HOLD_CYCLES - 1)) begin
        nl.locked   = 1'b0;
        nl.hold_cnt = '0;
        nl.idle_run = '0;
      end else begin
        nl.hold_cnt = ls.hold_cnt + 1'b1;
      end
    end
    // Serial to parallel: a group closes on its fifth bit.
    nl.sh    = {ls.sh[8:0], plain};
    sym      = {ls.sh[3:0], plain};
    dsym     = dec5(sym);
    nl.ones_run = plain ? ((ls.ones_run == 4'(IDLE_PAIR)) ? ls.ones_run
                                                          : ls.ones_run + 1'b1) : 4'h0;
    nl.bit_cnt  = (ls.bit_cnt == LAST_BIT) ? 3'h0 : ls.bit_cnt + 1'b1;
    nl.word.sym = sym;
    nl.word.eq  = eq_amount;
    nl.word.nib = dsym[3:0];
    nl.word.two = 1'b0;
    nl.word.dv  = 1'b0;
    nl.word.er  = 1'b0;
    nl.word.fc  = 1'b0;
    nl.word.raw = ls.cfg_s2[0];
    case (ls.pst)
      // Free groups; a zero after two idles may open a start delimiter.
      R_IDLE: begin
        emit = (ls.bit_cnt == LAST_BIT);
        if (!ls.cfg_s2[0] && (ls.cfg_s2[1] || ls.locked) && !plain &&
            ls.ones_run == 4'(IDLE_PAIR)) begin
          nl.pst     = R_ALIGN;
          nl.bit_cnt = J_PHASE + 1'b1;
          emit       = 1'b0;
          nl.seen_one = 1'b0;
        end
      end
      // First group must be J, second K; anything else is a false carrier.
      R_ALIGN: begin
        if (ls.bit_cnt == LAST_BIT) begin
          if (!ls.seen_one && sym == SYM_J) begin
            nl.seen_one = 1'b1;
          end else if (ls.seen_one && sym == SYM_K) begin
            emit        = 1'b1;
            nl.pst      = R_FRAME;
            nl.seen_one = 1'b0;
            nl.word.nib = NIB_PRE;
            nl.word.two = 1'b1;
            nl.word.dv  = 1'b1;
          end else begin
            emit        = 1'b1;
            nl.pst      = R_BAD;
            nl.word.nib = NIB_BAD;
            nl.word.two = ls.seen_one;
            nl.word.er  = 1'b1;
            nl.word.fc  = 1'b1;
            nl.seen_one = (sym == SYM_IDLE);
          end
        end
      end
      // Data until T then R, or two idles.
      R_FRAME: begin
        if (ls.bit_cnt == LAST_BIT) begin
          if (ls.seen_one && (sym == SYM_R || sym == SYM_IDLE)) begin
            nl.pst = R_IDLE;
          end else if (sym == SYM_T || sym == SYM_IDLE) begin
            nl.seen_one = 1'b1;
          end else begin
            emit        = 1'b1;
            nl.seen_one = 1'b0;
            nl.word.dv  = 1'b1;
            nl.word.er  = ~dsym[4];
          end
        end
      end
      // False carrier: 1110 with error on every non-idle group until two idles.
      R_BAD: begin
        if (ls.bit_cnt == LAST_BIT) begin
          if (sym == SYM_IDLE && ls.seen_one) begin
            nl.pst = R_IDLE;
          end else begin
            nl.seen_one = (sym == SYM_IDLE);
            emit        = ~nl.seen_one;
            nl.word.nib = NIB_BAD;
            nl.word.er  = 1'b1;
          end
        end
      end
      default: nl.pst = R_IDLE;
    endcase
    if (emit) begin
      nl.tog = ~ls.tog;
    end else begin
      nl.word = ls.word;
    end
  end

  // The descrambler, aligner and decoder run on the recovered bit clock.
  always_ff @(posedge rx_clk) begin
    if (!lrst_q[1]) begin
      ls <= '0;
    end else begin
      ls <= nl;
    end
  end

  // ==========================================================================
  // Core clock domain.
  // ==========================================================================
  // All state of the core clock side.
  typedef struct packed {
    logic            sd_s1;     // Signal detect, first sync stage.
    logic            sd_s2;     // Signal detect, second sync stage.
    logic            lk_s1;     // Lock, first sync stage.
    logic            lk_s2;     // Lock, second sync stage.
    logic            tg_s1;     // Word toggle, first sync stage.
    logic            tg_s2;     // Word toggle, second sync stage.
    logic            tg_s3;     // Word toggle, edge reference.
    link_state_e     lnk;       // Link monitor state.
    logic [UP_W-1:0] up_cnt;    // Qualify counter.
    logic [3:0]      rxd;       // Nibble to the MAC.
    logic            dv;        // Data valid to the MAC.
    logic            er;        // Error to the MAC.
    logic            stb;       // Nibble strobe.
    logic            pend;      // Second nibble still to report.
    logic [4:0]      sym;       // Last code-group.
    logic [FC_W-1:0] fc_cnt;    // False carrier events.
    logic [EQ_W-1:0] eq;        // Equalizer amount.
  } core_st_s;

  core_st_s cs;      // Registered core state.
  core_st_s nc;      // Next core state.
  logic     sd_eff;  // Signal detect after forcing.
  logic     enter;   // Conditions to qualify link-up.
  logic     take;    // A new word is stable in ls.word.

  // Link monitor and the nibble interface.
  always_comb begin
    nc       = cs;
    nc.sd_s1 = sig_det;
    nc.sd_s2 = cs.sd_s1;
    nc.lk_s1 = ls.locked;
    nc.lk_s2 = cs.lk_s1;
    nc.tg_s1 = ls.tog;
    nc.tg_s2 = cs.tg_s1;
    nc.tg_s3 = cs.tg_s2;
    sd_eff   = cs.sd_s2 | cfg.force_sd;
    enter    = sd_eff && (!cfg.lock_req || cs.lk_s2);
    case (cs.lnk)
      L_DOWN: begin
        if (!enter) begin
          nc.up_cnt = '0;
        end else if (cs.up_cnt == UP_W'(LINKUP_CYCLES - 1)) begin
          nc.lnk    = L_UP;
          nc.up_cnt = '0;
        end else begin
          nc.up_cnt = cs.up_cnt + 1'b1;
        end
      end
      L_UP: begin
        if (!sd_eff) begin
          nc.lnk = L_DOWN;
        end
      end
      default: nc.lnk = L_DOWN;
    endcase
    // The word held stable in ls.word is read once its toggle has settled.
    take   = cs.tg_s2 ^ cs.tg_s3;
    nc.stb = 1'b0;
    if (take) begin
      nc.eq  = ls.word.eq;
      nc.sym = ls.word.sym;
      if (ls.word.dv || ls.word.er || ls.word.raw) begin
        nc.rxd  = ls.word.nib;
        nc.dv   = ls.word.dv & (cs.lnk == L_UP);
        nc.er   = ls.word.er & (cs.lnk == L_UP);
        nc.stb  = 1'b1;
        nc.pend = ls.word.two;
      end
      if (ls.word.fc) begin
        nc.fc_cnt = cs.fc_cnt + 1'b1;
      end
    end else if (cs.pend) begin
      nc.stb  = 1'b1;
      nc.pend = 1'b0;
    end
  end

  // Core state register.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cs <= '0;
    end else begin
      cs <= nc;
    end
  end

  assign rxd               = cs.rxd;
  assign rx_dv             = cs.dv;
  assign rx_er             = cs.er;
  assign rx_stb            = cs.stb;
  assign rx_sym            = cs.sym;
  assign link_up           = (cs.lnk == L_UP);
  assign descr_locked      = cs.lk_s2;
  assign false_carrier_cnt = cs.fc_cnt;
  assign eq_level          = cs.eq;

  // ==========================================================================
  // Checks.
  // ==========================================================================
  nrz_decode_a: assert property (@(posedge rx_clk) disable iff (!lrst_q[1])
    $past(lrst_q[1]) |-> nrz_bit == (nrzi_now != $past(nrzi_now)))
    else $error("NRZ bit does not follow NRZI change");
  descr_xor_a: assert property (@(posedge rx_clk) disable iff (!lrst_q[1])
    (ls.locked && !ls.cfg_s2[1]) |-> plain == (nrz_bit ^ ls.lfsr[TAP_A] ^ ls.lfsr[TAP_B]))
    else $error("Descrambled bit is not line XOR key");
  lock_count_a: assert property (@(posedge rx_clk) disable iff (!lrst_q[1])
    $rose(ls.locked) |-> $past(ls.match_cnt) == CNT_W'(LOCK_BITS - 1))
    else $error("Lock taken without twelve idles");
  hold_renew_a: assert property (@(posedge rx_clk) disable iff (!lrst_q[1])
    (ls.locked && renew) |=> ls.locked && ls.hold_cnt == '0)
    else $error("Hold timer not restarted by idle run");
  hold_expire_a: assert property (@(posedge rx_clk) disable iff (!lrst_q[1])
    (ls.locked && !renew && ls.hold_cnt == HOLD_W'(HOLD_CYCLES - 1)) |=> !ls.locked)
    else $error("Lock kept after hold expiry");
  preamble_a: assert property (@(posedge rx_clk) disable iff (!lrst_q[1])
    (ls.pst == R_ALIGN && nl.pst == R_FRAME) |=> ls.word.nib == NIB_PRE && ls.word.two)
    else $error("J/K not replaced by preamble");
  bad_ssd_a: assert property (@(posedge rx_clk) disable iff (!lrst_q[1])
    (ls.pst == R_BAD && emit) |=> ls.word.er && ls.word.nib == NIB_BAD)
    else $error("False carrier word not 1110 with error");
  esd_end_a: assert property (@(posedge rx_clk) disable iff (!lrst_q[1])
    (ls.pst == R_FRAME && ls.bit_cnt == LAST_BIT && ls.seen_one && sym == SYM_R)
    |=> ls.pst == R_IDLE)
    else $error("End delimiter did not close the frame");
  link_qual_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(link_up) |-> $past(cs.up_cnt) == UP_W'(LINKUP_CYCLES - 1) && $past(enter))
    else $error("Link up before qualify time");
  fc_count_a: assert property (@(posedge clk) disable iff (!rst_n)
    (take && ls.word.fc) |=> cs.fc_cnt == $past(cs.fc_cnt) + 1'b1)
    else $error("False carrier count not advanced by one");
  lock_c: cover property (@(posedge rx_clk) disable iff (!lrst_q[1]) $rose(ls.locked));
  frame_c: cover property (@(posedge rx_clk) disable iff (!lrst_q[1])
    ls.pst == R_FRAME ##1 ls.pst == R_IDLE);
  bad_c: cover property (@(posedge rx_clk) disable iff (!lrst_q[1]) $rose(ls.pst == R_BAD));
  up_c: cover property (@(posedge clk) disable iff (!rst_n) $rose(link_up));

endmodule

// ===== fe_rx_pkg.sv
// ============================================================================
// Shared constants and types for the 100 Mb/s receive coding path.
// Assumes a 250 MHz core clock and a 125 MHz recovered symbol clock.
// ============================================================================
package fe_rx_pkg;

  // ==========================================================================
  // Clock rates and times.
  // ==========================================================================
  localparam int CLK_MHZ    = 250;                   // Core clock rate.
  localparam int LINK_MHZ   = 125;                   // Recovered bit clock rate.
  localparam int HOLD_US    = 722;                   // Descrambler hold period.
  localparam int HOLD_CYC   = HOLD_US * LINK_MHZ;    // Longest time, bit clocks.
  localparam int LINKUP_US  = 395;                   // Signal detect qualify time.
  localparam int LINKUP_CYC = LINKUP_US * CLK_MHZ;   // Least time, core clocks.

  // ==========================================================================
  // Symbol counts.
  // ==========================================================================
  localparam int SYM_BITS      = 5;                  // Bits per code-group.
  localparam int LOCK_IDLES    = 12;                 // Idles needed for lock.
  localparam int LOCK_BITS     = LOCK_IDLES * SYM_BITS;
  localparam int IDLE_RUN_BITS = 58;                 // Idle bits that renew hold.
  localparam int IDLE_PAIR     = 2 * SYM_BITS;       // Two idle code-groups.
  localparam int CNT_W         = 6;                  // Width of match and idle run counters.
  localparam int EQ_W          = 6;                  // Equalizer amount width.

  // ==========================================================================
  // Code-groups, nibbles and scrambler taps.
  // ==========================================================================
  localparam logic [4:0] SYM_IDLE  = 5'h1f;          // 11111.
  localparam logic [4:0] SYM_J     = 5'h18;          // 11000.
  localparam logic [4:0] SYM_K     = 5'h11;          // 10001.
  localparam logic [4:0] SYM_T     = 5'h0d;          // 01101.
  localparam logic [4:0] SYM_R     = 5'h07;          // 00111.
  localparam logic [3:0] NIB_PRE   = 4'h5;           // Preamble nibble.
  localparam logic [3:0] NIB_BAD   = 4'he;           // False carrier nibble.
  localparam logic [2:0] J_PHASE   = 3'h2;           // Bits of J before its first zero.
  localparam logic [2:0] LAST_BIT  = 3'h4;           // Index of a group's last bit.
  localparam logic [1:0] MLT_ZERO  = 2'h0;           // Middle MLT-3 level.
  localparam int         LFSR_W    = 11;             // Key generator length.
  localparam int         TAP_A     = 10;             // x^11 term.
  localparam int         TAP_B     = 8;              // x^9 term.

  // ==========================================================================
  // Types.
  // ==========================================================================
  // Configuration bits of pcs_config_reg that steer this path.
  typedef struct packed {
    logic force_sd;      // Force signal detect active.
    logic lock_req;      // Require descrambler lock to enter link-up.
    logic descr_bypass;  // Skip the descrambler.
    logic rx_bypass;     // Skip alignment and decoding.
  } pcs_cfg_s;

  // Receive states of the code-group path.
  typedef enum logic [1:0] {R_IDLE, R_ALIGN, R_FRAME, R_BAD} rx_state_e;

  // Link state of the integrity monitor.
  typedef enum logic {L_DOWN, L_UP} link_state_e;

  // One symbol report handed from the bit clock to the core clock.
  typedef struct packed {
    logic [4:0]      sym;   // Code-group as received.
    logic [3:0]      nib;   // Decoded nibble.
    logic            two;   // Nibble is reported twice.
    logic            dv;    // Nibble is frame data.
    logic            er;    // Nibble carries an error.
    logic            fc;    // First word of a false carrier.
    logic            raw;   // Decoding is bypassed.
    logic [EQ_W-1:0] eq;    // Equalizer amount.
  } rx_word_s;

endpackage

// ===== fe_line_partner.sv
// Far end of the twisted pair: scrambles 5B groups and sends them as MLT-3.
// Assumes rx_clk is the bench's bit clock; idles go out when no group waits.
`timescale 1ns/10ps
module fe_line_partner (
  // Bit clock and line level.
  input  wire logic       rx_clk,
  output logic      [1:0] mlt3_sym = 2'h0
);
  logic [4:0]  q[$];            // Plain groups waiting to go out.
  logic [4:0]  grp  = 5'h1f;    // Group being sent, first bit is the top one.
  logic [2:0]  idx  = 3'h0;     // Bit position within the group.
  logic [10:0] lfsr = 11'h5a5;  // Scrambler state; any nonzero seed works.
  logic        key;             // Key bit of this bit time.
  logic [1:0]  ph   = 2'h0;     // MLT-3 phase: 0, +, 0, -.
  logic        plain_tx = 1'b0; // Send groups unscrambled; the key still runs.
  // One bit per edge; the level changes on every scrambled one.
  always @(posedge rx_clk) begin
    if (idx == 3'h0) grp = (q.size() > 0) ? q.pop_front() : 5'h1f;
    key  = lfsr[10] ^ lfsr[8];
    lfsr = {lfsr[9:0], key};
    if (grp[3'h4 - idx] ^ (key & ~plain_tx)) ph = ph + 2'h1;
    idx  = (idx == 3'h4) ? 3'h0 : idx + 3'h1;
    mlt3_sym <= #1 ph[0] ? {ph[1], 1'b1} : 2'h0;
  end
endmodule

// ===== tb_top.sv
// Self-checking bench for the receive coding path.
// Assumes fe_rx_pkg and the line partner model are compiled first.
`timescale 1ns/10ps
module tb_top;
  import fe_rx_pkg::*;
  // ==========================================================================
  // Signals.
  // ==========================================================================
  logic            clk = 1'b0, rx_clk = 1'b0, rst_n = 1'b0, sig_det = 1'b1;
  logic [EQ_W-1:0] eq_amount = 6'h2b, eq_level;
  pcs_cfg_s        cfg = '0;
  logic [3:0]      rxd;
  logic            rx_dv, rx_er, rx_stb, link_up, descr_locked;
  logic [4:0]      rx_sym;
  logic [1:0]      mlt3_sym;
  logic [15:0]     false_carrier_cnt;
  logic [5:0]      mq[$];       // Reported {nibble, valid, error}.
  int              errors = 0, cmp_count = 0;
  always #2 clk = ~clk;
  always #24 rx_clk = ~rx_clk;
  fe_rx_path #(.HOLD_CYCLES(200), .LINKUP_CYCLES(20)) u_fe_rx_path (
    .clk(clk), .rst_n(rst_n), .rx_clk(rx_clk), .mlt3_sym(mlt3_sym),
    .eq_amount(eq_amount), .sig_det(sig_det), .cfg(cfg), .rxd(rxd), .rx_dv(rx_dv),
    .rx_er(rx_er), .rx_stb(rx_stb), .rx_sym(rx_sym), .link_up(link_up),
    .descr_locked(descr_locked), .false_carrier_cnt(false_carrier_cnt),
    .eq_level(eq_level));
  fe_line_partner u_fe_line_partner (.rx_clk(rx_clk), .mlt3_sym(mlt3_sym));
  // Every strobe is logged once, at the edge that sees it high.
  always @(posedge clk) if (rx_stb === 1'b1) mq.push_back({rxd, rx_dv, rx_er});
  // ==========================================================================
  // Shared tasks.
  // ==========================================================================
  task check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task stop_test;
    if (errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Waits a bounded time for lock (sel 0) or link (sel 1) to reach v.
  task wait_on(input bit sel, input logic v, input int lim);
    int n;
    n = 0;
    while (((sel ? link_up : descr_locked) !== v) && n < lim) begin
      @(posedge clk);
      n++;
    end
    if (n == lim) begin
      errors++;
      stop_test;
    end
    #1;
    check(sel ? link_up : descr_locked, v);
  endtask
  // Sends groups, then lets idles flush the pipeline.
  task send(input logic [4:0] g[$]);
    mq.delete();
    foreach (g[i]) u_fe_line_partner.q.push_back(g[i]);
    repeat (5 * g.size() + 14) @(posedge rx_clk);
    #1;
  endtask
  // ==========================================================================
  // Scenarios.
  // ==========================================================================
  task t_lock;
    check(false_carrier_cnt, 16'h0000);
    wait_on(0, 1'b1, 3000);
    wait_on(1, 1'b1, 100);
  endtask
  task t_frame;
    logic [5:0] ex[6];
    ex = '{6'h16, 6'h16, 6'h02, 6'h06, 6'h0a, 6'h3e};
    send('{SYM_J, SYM_K, 5'h1e, 5'h09, 5'h14, 5'h1d, SYM_T, SYM_R});
    check(mq.size(), 16'h0006);
    foreach (ex[i]) check(mq[i], ex[i]);
    check(eq_level, eq_amount);
  endtask
  task t_bad;
    send('{5'h1e, 5'h09});
    check(mq.size() > 1, 16'h0001);
    foreach (mq[i]) check(mq[i], 6'h39);
    check(false_carrier_cnt, 16'h0001);
  endtask
  // Descrambler bypassed at both ends; the bench flag lags one bit clock to
  // match the two-stage sync of the bypass bit inside the block.
  task t_bypass;
    cfg.descr_bypass = 1'b1;
    @(posedge rx_clk);
    #1 u_fe_line_partner.plain_tx = 1'b1;
    repeat (20) @(posedge rx_clk);
    #1 t_frame;
    cfg.descr_bypass = 1'b0;
    @(posedge rx_clk);
    #1 u_fe_line_partner.plain_tx = 1'b0;
  endtask
  // Raw mode: every group is strobed undecoded with valid and error low.
  task t_raw;
    cfg.rx_bypass = 1'b1;
    repeat (30) @(posedge rx_clk);
    #1 mq.delete();
    repeat (20) @(posedge rx_clk);
    #1;
    check(mq.size() > 2, 16'h0001);
    foreach (mq[i]) check(mq[i], 6'h00);
    check(rx_sym, SYM_IDLE);
    cfg.rx_bypass = 1'b0;
  endtask
  task t_link;
    sig_det = 1'b0;
    wait_on(1, 1'b0, 20);
    cfg.force_sd = 1'b1;
    wait_on(1, 1'b1, 100);
    cfg = '0;
    sig_det = 1'b1;
  endtask
  // Long run with no idles: lock drops, link entry then waits for relock.
  task t_hold;
    logic [4:0] g[$];
    g = '{SYM_J, SYM_K};
    repeat (50) g.push_back(5'h1e);
    cfg.lock_req = 1'b1;
    send(g);
    check(descr_locked, 1'b0);
    check(link_up, 1'b1);
    sig_det = 1'b0;
    repeat (10) @(posedge clk);
    #1 sig_det = 1'b1;
    repeat (40) @(posedge clk);
    check(link_up, 1'b0);
    wait_on(0, 1'b1, 3000);
    wait_on(1, 1'b1, 100);
  endtask
  initial begin
    repeat (40) @(posedge clk);
    #1 rst_n = 1'b1;
    t_lock;
    t_frame;
    t_bad;
    t_bypass;
    t_raw;
    t_link;
    t_hold;
    stop_test;
  end
endmodule
